/* verilog/rdlc_top.sv */
// Lane configuration registers, serial slave and power control of the redriver
`timescale 1ns/10ps
`include "rdlc_params.svh"

module rdlc_top (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire logic                    scl_in,
	input  wire logic                    sda_in,
	output logic                         sda_out,
	output logic                         sda_oe,
	input  wire logic                    cable_absent_n,
	input  wire logic                    reg_mode_sel,
	input  wire logic                    pkg_32pin,
	input  wire logic [3:0]              eq_or_addr_strap,
	input  wire logic [1:0]              swing_strap,
	input  wire logic                    gain0_strap,
	input  wire logic                    gain1_or_cfg_reset_n,
	output rdlc_pkg::rdlc_lane_out_t     lane0_out,
	output rdlc_pkg::rdlc_lane_out_t     lane1_out,
	output rdlc_pkg::rdlc_power_t        power_out
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------

	// Two-bit code to one-hot level select
	function automatic logic [3:0] code_to_level(input logic [1:0] code);
		logic [3:0] lvl;
		lvl = 4'h0;
		lvl[code] = 1'b1;
		return lvl;
	endfunction

	// Build one lane's analog settings from a config byte
	function automatic rdlc_pkg::rdlc_lane_out_t lane_decode(input logic [7:0] cfg);
		rdlc_pkg::rdlc_lane_out_t o;
		o.eq_boost_sel = cfg[`RDLC_CFG_EQ_MSB:`RDLC_CFG_EQ_LSB];
		o.gain_level   = code_to_level(cfg[`RDLC_CFG_FG_MSB:`RDLC_CFG_FG_LSB]);
		o.swing_level  = code_to_level(cfg[`RDLC_CFG_SW_MSB:`RDLC_CFG_SW_LSB]);
		return o;
	endfunction

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	localparam int SYN_W = 13;
	logic [SYN_W-1:0] syn1_r;     // First stage, read only by second stage
	logic [SYN_W-1:0] syn2_r;     // Second stage, safe to use
	logic             scl_d_r;    // Previous synchronised clock line
	logic             sda_d_r;    // Previous synchronised data line

	// Two flops on every pin input
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			syn1_r <= '1;
			syn2_r <= '1;
		end else begin
			syn1_r <= {scl_in, sda_in, cable_absent_n, reg_mode_sel, pkg_32pin,
				eq_or_addr_strap, swing_strap, gain0_strap, gain1_or_cfg_reset_n};
			syn2_r <= syn1_r;
		end
	end

	wire       scl_s   = syn2_r[12];  // Serial clock
	wire       sda_s   = syn2_r[11];  // Serial data
	wire       absent  = syn2_r[10];  // High when no cable
	wire       regmode = syn2_r[9];   // Register mode
	wire       pkg32   = syn2_r[8];   // Small package strap
	wire [3:0] eq_pin  = syn2_r[7:4]; // Equalizer or address straps
	wire [1:0] sw_pin  = syn2_r[3:2]; // Swing straps
	wire       fg0_pin = syn2_r[1];   // Gain bit 0 strap
	wire       fg1_pin = syn2_r[0];   // Gain bit 1 or register reset

	// Delayed copies for edge finding
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// Register reset acts only where the shared pin serves as reset
	wire cfg_clr = regmode & ~fg1_pin;

	// Own address from straps
	wire [6:0] own_addr = {`RDLC_ADDR_PREFIX, eq_pin[3:1], pkg32 ? 1'b1 : eq_pin[0]};

	// ---------------------------------------------------------------
	// Serial slave
	// ---------------------------------------------------------------
	rdlc_pkg::rdlc_state_t state_r;   // Slave sequence state
	logic [3:0]            cnt_r;     // Bits taken in this byte
	logic [7:0]            rx_r;      // Received shift register
	logic [7:0]            tx_r;      // Transmit shift register
	logic                  rw_r;      // Transfer is a read
	logic [2:0]            ptr_r;     // Byte pointer within the map
	logic                  ptr_ovf_r; // Pointer wrapped past byte 7
	logic                  sda_oe_r;  // Pull data line low
	logic [7:0]            pd_r;      // Lane power-down byte
	logic [7:0]            cfg0_r;    // Lane 0 config byte
	logic [7:0]            cfg1_r;    // Lane 1 config byte
	logic [7:0]            rd_byte;   // Byte at the pointer

	// Read multiplexer; reserved and unmapped bytes read zero
	always_comb begin
		rd_byte = 8'h00;
		if (!ptr_ovf_r) begin
			case (ptr_r)
				`RDLC_OFS_LANE_PD:   rd_byte = pd_r;
				`RDLC_OFS_LANE0_CFG: rd_byte = cfg0_r;
				`RDLC_OFS_LANE1_CFG: rd_byte = cfg1_r;
				default:             rd_byte = 8'h00;
			endcase
		end
	end

	wire wr_strobe = (state_r == rdlc_pkg::ST_WR) && scl_fall &&
		(cnt_r == `RDLC_BITS_PER_BYTE);

	// Byte sequencing, bit shifting and line drive; never stretches the clock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r   <= rdlc_pkg::ST_IDLE;
			cnt_r     <= 4'h0;
			rx_r      <= 8'h00;
			tx_r      <= 8'h00;
			rw_r      <= 1'b0;
			ptr_r     <= 3'h0;
			ptr_ovf_r <= 1'b0;
			sda_oe_r  <= 1'b0;
		end else if (start_c) begin
			// Every transfer restarts at byte zero
			state_r   <= rdlc_pkg::ST_ADDR;
			cnt_r     <= 4'h0;
			ptr_r     <= 3'h0;
			ptr_ovf_r <= 1'b0;
			sda_oe_r  <= 1'b0;
		end else if (stop_c) begin
			// Stop ends any transfer after the last whole byte
			state_r  <= rdlc_pkg::ST_IDLE;
			sda_oe_r <= 1'b0;
		end else begin
			// Sample on rising clock while a byte is in flight
			if (scl_rise && cnt_r != `RDLC_BITS_PER_BYTE) begin
				rx_r  <= {rx_r[6:0], sda_s};
				cnt_r <= cnt_r + 4'h1;
			end
			// Master refuses further read data
			if (scl_rise && state_r == rdlc_pkg::ST_RD_ACK && sda_s) begin
				state_r <= rdlc_pkg::ST_IDLE;
			end
			if (scl_fall) begin
				case (state_r)
					rdlc_pkg::ST_ADDR: begin
						// Acknowledge only our own address
						if (cnt_r == `RDLC_BITS_PER_BYTE) begin
							if (rx_r[7:1] == own_addr) begin
								rw_r     <= rx_r[0];
								sda_oe_r <= 1'b1;
								state_r  <= rdlc_pkg::ST_ADDR_ACK;
							end else begin
								state_r <= rdlc_pkg::ST_IDLE;
							end
						end
					end
					rdlc_pkg::ST_ADDR_ACK, rdlc_pkg::ST_RD_ACK: begin
						// Start a data byte; reads drive the MSB now
						cnt_r <= 4'h0;
						if (rw_r) begin
							tx_r     <= {rd_byte[6:0], 1'b0};
							sda_oe_r <= ~rd_byte[7];
							state_r  <= rdlc_pkg::ST_RD;
						end else begin
							sda_oe_r <= 1'b0;
							state_r  <= rdlc_pkg::ST_WR;
						end
					end
					rdlc_pkg::ST_WR: begin
						// Whole byte taken: acknowledge and advance
						if (cnt_r == `RDLC_BITS_PER_BYTE) begin
							sda_oe_r <= 1'b1;
							state_r  <= rdlc_pkg::ST_WR_ACK;
						end
					end
					rdlc_pkg::ST_WR_ACK: begin
						// Release line and take the next byte
						sda_oe_r <= 1'b0;
						cnt_r    <= 4'h0;
						state_r  <= rdlc_pkg::ST_WR;
					end
					rdlc_pkg::ST_RD: begin
						if (cnt_r == `RDLC_BITS_PER_BYTE) begin
							// Release for the master's acknowledge
							sda_oe_r <= 1'b0;
							state_r  <= rdlc_pkg::ST_RD_ACK;
						end else begin
							sda_oe_r <= ~tx_r[7];
							tx_r     <= {tx_r[6:0], 1'b0};
						end
					end
					default: begin
						sda_oe_r <= 1'b0;
					end
				endcase
				// Pointer advances after each whole data byte
				if ((state_r == rdlc_pkg::ST_WR || state_r == rdlc_pkg::ST_RD) &&
					cnt_r == `RDLC_BITS_PER_BYTE) begin
					ptr_r <= ptr_r + 3'h1;
					if (ptr_r == 3'h7) begin
						ptr_ovf_r <= 1'b1;
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------

	// Register writes; reserved bytes and unmapped bytes are dropped
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pd_r   <= `RDLC_RST_LANE_PD;
			cfg0_r <= `RDLC_RST_LANE_CFG;
			cfg1_r <= `RDLC_RST_LANE_CFG;
		end else if (cfg_clr) begin
			pd_r   <= `RDLC_RST_LANE_PD;
			cfg0_r <= `RDLC_RST_LANE_CFG;
			cfg1_r <= `RDLC_RST_LANE_CFG;
		end else if (wr_strobe && !ptr_ovf_r) begin
			case (ptr_r)
				`RDLC_OFS_LANE_PD:   pd_r   <= rx_r;
				`RDLC_OFS_LANE0_CFG: cfg0_r <= rx_r;
				`RDLC_OFS_LANE1_CFG: cfg1_r <= rx_r;
				default:             pd_r   <= pd_r;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Lane settings and power control
	// ---------------------------------------------------------------
	logic [7:0] strap_cfg; // Settings from strap pins
	logic [3:0] lane_pd;   // Per-lane power-down from register
	logic [3:0] lane_on;   // Lane running

	always_comb begin
		strap_cfg = {eq_pin, fg1_pin, fg0_pin, sw_pin};
		// Reserved low bits of byte 2 play no part in power control
		lane_pd = {pd_r[`RDLC_PD_LANE3_BIT], pd_r[`RDLC_PD_LANE2_BIT],
			pd_r[`RDLC_PD_LANE1_BIT], pd_r[`RDLC_PD_LANE0_BIT]};
		// Global power-down overrides register contents
		lane_on = absent ? 4'h0 : (regmode ? ~lane_pd : 4'hf);
	end

	// Register all outputs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lane0_out <= '0;
			lane1_out <= '0;
			power_out <= '0;
			sda_out   <= 1'b0;
			sda_oe    <= 1'b0;
		end else begin
			lane0_out <= lane_decode(regmode ? cfg0_r : strap_cfg);
			lane1_out <= lane_decode(regmode ? cfg1_r : strap_cfg);
			power_out.lane_active  <= lane_on;
			power_out.term_weak_pu <= ~lane_on;
			power_out.out_hiz      <= ~lane_on;
			sda_out <= 1'b0;
			sda_oe  <= sda_oe_r;
		end
	end

endmodule

/* shared/rdlc_params.svh */
// Register offsets, field positions, reset values and address constants
`ifndef RDLC_PARAMS_SVH
`define RDLC_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define RDLC_OFS_RSVD0      3'h0
`define RDLC_OFS_RSVD1      3'h1
`define RDLC_OFS_LANE_PD    3'h2
`define RDLC_OFS_LANE0_CFG  3'h3
`define RDLC_OFS_LANE1_CFG  3'h4

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RDLC_PD_LANE3_BIT   7
`define RDLC_PD_LANE2_BIT   6
`define RDLC_PD_LANE1_BIT   5
`define RDLC_PD_LANE0_BIT   4
`define RDLC_CFG_EQ_MSB     7
`define RDLC_CFG_EQ_LSB     4
`define RDLC_CFG_FG_MSB     3
`define RDLC_CFG_FG_LSB     2
`define RDLC_CFG_SW_MSB     1
`define RDLC_CFG_SW_LSB     0

// ---------------------------------------------------------------
// Reset values and address
// ---------------------------------------------------------------
`define RDLC_RST_LANE_PD    8'h00
`define RDLC_RST_LANE_CFG   8'h00
`define RDLC_ADDR_PREFIX    3'h7
`define RDLC_BITS_PER_BYTE  4'h8

`endif

/* shared/rdlc_pkg.sv */
// Types shared by the redriver lane configuration block
package rdlc_pkg;

	// Serial slave sequencing states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK
	} rdlc_state_t;

	// Per-lane settings handed to the analog lane
	typedef struct packed {
		logic [3:0] eq_boost_sel;   // Equalizer boost code
		logic [3:0] gain_level;     // One-hot flat gain level
		logic [3:0] swing_level;    // One-hot swing limit level
	} rdlc_lane_out_t;

	// Per-lane power control, one bit per lane
	typedef struct packed {
		logic [3:0] lane_active;    // Lane running
		logic [3:0] term_weak_pu;   // Input termination in weak pull-up
		logic [3:0] out_hiz;        // Output driver high impedance
	} rdlc_power_t;

endpackage

/* test/rdlc_sva.sv */
// Checker of lane settings, power control and data-pin timing
`timescale 1ns/10ps
module rdlc_sva (
	input wire logic                     clk,
	input wire logic                     sys_rst,
	input wire logic                     scl_in,
	input wire logic                     sda_oe,
	input wire logic                     cable_absent_n,
	input wire logic                     reg_mode_sel,
	input wire logic [3:0]               eq_or_addr_strap,
	input wire logic [1:0]               swing_strap,
	input wire logic                     gain0_strap,
	input wire logic                     gain1_or_cfg_reset_n,
	input wire rdlc_pkg::rdlc_lane_out_t lane0_out,
	input wire rdlc_pkg::rdlc_lane_out_t lane1_out,
	input wire rdlc_pkg::rdlc_power_t    power_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ----------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------
	// Strap mode with the equalizer, swing and gain straps held steady
	sequence s_strap_hold;
		(!reg_mode_sel && $stable({eq_or_addr_strap, swing_strap, gain0_strap,
			gain1_or_cfg_reset_n}))[*8];
	endsequence
	// Register clear held in register mode, cable present
	sequence s_clear_hold;
		(reg_mode_sel && !gain1_or_cfg_reset_n && !cable_absent_n)[*8];
	endsequence

	// ----------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------
	a_absent_all_down: assert property (
		cable_absent_n[*8] |-> power_out.lane_active == 4'h0 && power_out.out_hiz == 4'hf)
		else $error("cable absent but lanes not down");
	a_down_pins_paired: assert property (
		power_out.term_weak_pu == power_out.out_hiz &&
		(power_out.lane_active & power_out.out_hiz) == 4'h0)
		else $error("down lane termination and output disagree");
	a_present_all_run: assert property (
		(!cable_absent_n && !reg_mode_sel)[*8] |-> power_out.lane_active == 4'hf)
		else $error("cable present in strap mode but a lane is down");
	a_strap_eq_code: assert property (
		s_strap_hold |-> lane0_out.eq_boost_sel == eq_or_addr_strap &&
		lane1_out.eq_boost_sel == eq_or_addr_strap)
		else $error("equalizer code differs from straps");
	a_strap_gain_level: assert property (
		s_strap_hold |-> lane0_out.gain_level == 4'h1 << {gain1_or_cfg_reset_n, gain0_strap}
		&& lane1_out.gain_level == lane0_out.gain_level)
		else $error("gain level differs from straps");
	a_strap_swing_level: assert property (
		s_strap_hold |-> lane0_out.swing_level == 4'h1 << swing_strap &&
		lane1_out.swing_level == lane0_out.swing_level)
		else $error("swing level differs from straps");
	a_clear_defaults: assert property (
		s_clear_hold |-> lane0_out == 12'h011 && lane1_out == 12'h011 &&
		power_out.lane_active == 4'hf)
		else $error("register clear left settings in place");
	a_ack_scl_low: assert property (
		$changed(sda_oe) |-> !scl_in)
		else $error("data line drive changed while clock high");
endmodule

/* test/rdlc_i2c_master.sv */
// Serial bus master model driving the clock and data lines
`timescale 1ns/10ps
module rdlc_i2c_master (
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	// Quarter of a 125 ns bit period
	localparam realtime Q = 31.25;

	// Both lines released outside frames, clock stands still
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Start or repeated start: data falls while clock high
	task automatic start();
		sda_drv = 1'b1;
		#Q scl = 1'b1;
		#Q sda_drv = 1'b0;
		#(2*Q) scl = 1'b0;
	endtask
	// Stop: data rises while clock high
	task automatic stop();
		#Q sda_drv = 1'b0;
		#Q scl = 1'b1;
		#Q sda_drv = 1'b1;
		#Q;
	endtask
	// One bit: data set in clock low, line sampled mid-high
	task automatic clk_bit(input logic b, output logic s);
		#Q sda_drv = b;
		#Q scl = 1'b1;
		#Q s = sda_line;
		#Q scl = 1'b0;
	endtask
	// Byte out MSB first, then the acknowledge slot
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], s);
		end
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
	// Byte in MSB first, then master acknowledge or not
	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, d[i]);
		end
		clk_bit(nack, s);
	endtask
endmodule

/* test/testbench.sv */
// Self-checking bench of the redriver lane configuration block
`timescale 1ns/10ps
bind rdlc_top rdlc_sva chk_u (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_oe(sda_oe),
	.cable_absent_n(cable_absent_n), .reg_mode_sel(reg_mode_sel),
	.eq_or_addr_strap(eq_or_addr_strap), .swing_strap(swing_strap),
	.gain0_strap(gain0_strap), .gain1_or_cfg_reset_n(gain1_or_cfg_reset_n),
	.lane0_out(lane0_out), .lane1_out(lane1_out), .power_out(power_out));
module testbench;
	logic                     clk = 1'b0;
	logic                     sys_rst = 1'b1;
	logic                     absent = 1'b0;
	logic                     mode = 1'b1;
	logic                     pkg32 = 1'b0;
	logic [3:0]               strap = 4'ha;
	logic [1:0]               sw = 2'h0;
	logic                     g0 = 1'b0;
	logic                     g1 = 1'b1;
	logic                     m_scl;
	logic                     m_sda;
	logic                     oe;
	rdlc_pkg::rdlc_lane_out_t l0;
	rdlc_pkg::rdlc_lane_out_t l1;
	rdlc_pkg::rdlc_power_t    pw;
	int                       miscompares = 0;
	int                       n_checks = 0;
	logic [7:0]               z [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic                     sda_wire;
	logic                     so;

	// Open-drain data line with pull-up
	assign sda_wire = oe ? (m_sda & so) : m_sda;

	initial begin
		forever #4 clk = ~clk;
	end

	rdlc_top dut_u (.clk(clk), .sys_rst(sys_rst), .scl_in(m_scl), .sda_in(sda_wire),
		.sda_out(so), .sda_oe(oe), .cable_absent_n(absent), .reg_mode_sel(mode),
		.pkg_32pin(pkg32), .eq_or_addr_strap(strap), .swing_strap(sw), .gain0_strap(g0),
		.gain1_or_cfg_reset_n(g1), .lane0_out(l0), .lane1_out(l1), .power_out(pw));
	rdlc_i2c_master mst_u (.sda_line(sda_wire), .scl(m_scl), .sda_drv(m_sda));

	// -----------------------------------------------------
	// Helpers
	// -----------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Write n bytes from register zero; a refused address sends none
	task automatic reg_wr(input logic [7:0] a, input logic ea, input logic [7:0] b [5],
		input int n);
		logic ack;
		mst_u.start();
		mst_u.wr_byte(a, ack);
		check(12'(ack), 12'(ea));
		for (int i = 0; i < n && ea; i++) begin
			mst_u.wr_byte(b[i], ack);
			check(12'(ack), 12'h001);
		end
		mst_u.stop();
		step(10);
	endtask
	// Read all five bytes and compare
	task automatic reg_rd(input logic [7:0] e [5]);
		logic       ack;
		logic [7:0] d;
		mst_u.start();
		mst_u.wr_byte(8'hf5, ack);
		check(12'(ack), 12'h001);
		for (int i = 0; i < 5; i++) begin
			mst_u.rd_byte(i == 4, d);
			check(12'(d), 12'(e[i]));
		end
		mst_u.stop();
	endtask

	// -----------------------------------------------------
	// Scenarios
	// -----------------------------------------------------
	task automatic t_defaults();
		reg_rd(z);
		check(l0, 12'h011);
		check(l1, 12'h011);
		check(pw, 12'hf00);
	endtask
	task automatic t_strap();
		mode = 1'b0;
		for (int i = 0; i < 16; i++) begin
			{g1, g0, sw} = 4'(i);
			strap = 4'(i);
			step(12);
			check(l0, {strap, 4'h1 << {g1, g0}, 4'h1 << sw});
			check(l1, l0);
		end
		{mode, g1, strap} = 6'h3a;
		step(12);
	endtask
	task automatic t_write_read();
		// Gain code 10 and a fixed-swing code, lanes 2 and 0 down
		reg_wr(8'hf4, 1'b1, '{8'haa, 8'h55, 8'h5f, 8'h39, 8'hf8}, 5);
		reg_rd('{8'h00, 8'h00, 8'h5f, 8'h39, 8'hf8});
		check(l0, 12'h342);
		check(l1, 12'hf41);
		check(pw, 12'ha55);
	endtask
	task automatic t_addr_partial();
		reg_wr(8'hf6, 1'b0, z, 0);
		pkg32 = 1'b1;
		step(10);
		reg_wr(8'hf4, 1'b0, z, 0);
		reg_wr(8'hf6, 1'b1, '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00}, 3);
		check(pw, 12'h788);
		check(l0, 12'h342);
		pkg32 = 1'b0;
		step(10);
	endtask
	task automatic t_absent();
		absent = 1'b1;
		step(12);
		check(pw, 12'h0ff);
		absent = 1'b0;
		step(12);
		check(pw, 12'h788);
	endtask
	task automatic t_clear();
		g1 = 1'b0;
		step(12);
		g1 = 1'b1;
		step(10);
		reg_rd(z);
		check(l0, 12'h011);
		check(pw, 12'hf00);
	endtask

	// Run bound cuts a hang short
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		give_verdict();
	end

	initial begin
		step(20);
		sys_rst = 1'b0;
		step(10);
		t_defaults();
		t_strap();
		t_write_read();
		t_addr_partial();
		t_absent();
		t_clear();
		give_verdict();
	end
endmodule
